// file: verilog/timer_channel_io_control.sv
// pin function control of timer channels 1 and 2, AXI4-Lite slave
// counter, compare logic and channel 0 sit outside; their events
// arrive as one-cycle pulses on aclk, pins arrive asynchronously
`timescale 1ns/10ps

module timer_channel_io_control (
    // clock and reset
    input  wire  logic                              aclk,
    input  wire  logic                              aresetn,
    // axi4-lite write address
    input  wire  logic [timer_io_pkg::ADDR_W-1:0]   awaddr,
    input  wire  logic [2:0]                        awprot,
    input  wire  logic                              awvalid,
    output logic                                    awready,
    // axi4-lite write data
    input  wire  logic [timer_io_pkg::DATA_W-1:0]   wdata,
    input  wire  logic [3:0]                        wstrb,
    input  wire  logic                              wvalid,
    output logic                                    wready,
    // axi4-lite write response
    output logic [1:0]                              bresp,
    output logic                                    bvalid,
    input  wire  logic                              bready,
    // axi4-lite read address
    input  wire  logic [timer_io_pkg::ADDR_W-1:0]   araddr,
    input  wire  logic [2:0]                        arprot,
    input  wire  logic                              arvalid,
    output logic                                    arready,
    // axi4-lite read data
    output logic [timer_io_pkg::DATA_W-1:0]         rdata,
    output logic [1:0]                              rresp,
    output logic                                    rvalid,
    input  wire  logic                              rready,
    // timer core side
    input  wire  logic [timer_io_pkg::CNT_W-1:0]    count_value,
    input  wire  timer_io_pkg::timer_events_t       events,
    output timer_io_pkg::capture_t                  capture,
    // pins: ch1_pin_a, ch1_pin_b, ch2_pin_a, ch2_pin_b
    input  wire  logic [timer_io_pkg::N_REG-1:0]    pin_in,
    output timer_io_pkg::pin_drive_t                pin_drive
);

    localparam int N = timer_io_pkg::N_REG;
    localparam int W = timer_io_pkg::FLD_W;
    localparam int WORD_LSB_P = timer_io_pkg::WORD_LSB;
    localparam logic [N-1:0] LEVEL_RESET_P = timer_io_pkg::LEVEL_RESET;

    // control registers
    logic [timer_io_pkg::CTRL_W-1:0] ch1_ctrl_q;
    logic [timer_io_pkg::CTRL_W-1:0] ch2_ctrl_q;

    // axi state
    logic                            awready_q;
    logic                            wready_q;
    logic                            aw_have_q;
    logic                            w_have_q;
    logic [timer_io_pkg::ADDR_W-1:0] aw_addr_q;
    logic [timer_io_pkg::CTRL_W-1:0] w_data_q;
    logic                            w_strb_q;
    logic                            bvalid_q;
    logic [1:0]                      bresp_q;
    logic                            arready_q;
    logic                            rvalid_q;
    logic [1:0]                      rresp_q;
    logic [timer_io_pkg::DATA_W-1:0] rdata_q;

    // pin synchroniser and edge history
    logic [N-1:0] pin_s1_q;
    logic [N-1:0] pin_s2_q;
    logic [N-1:0] pin_s3_q;

    // pin drive and capture state
    logic [N-1:0]                   level_q;
    logic [N-1:0]                   level_d;
    logic [N-1:0]                   oe_n_q;
    logic [N-1:0]                   oe_n_d;
    logic [N-1:0]                   cap_stb_q;
    logic [N-1:0]                   cap_trig;
    logic [timer_io_pkg::CNT_W-1:0] cap_q [N];
    logic [timer_io_pkg::CNT_W-1:0] cap_d [N];
    logic [timer_io_pkg::CNT_W-1:0] cap_val_q;
    logic [timer_io_pkg::CNT_W-1:0] cap_val_d;

    // field split, index 0 ch1 a, 1 ch1 b, 2 ch2 a, 3 ch2 b
    logic [W-1:0] fld [N];
    logic [N-1:0] fld_wr;

    assign fld[0] = ch1_ctrl_q[W-1:0];
    assign fld[1] = ch1_ctrl_q[2*W-1:W];
    assign fld[2] = ch2_ctrl_q[W-1:0];
    assign fld[3] = ch2_ctrl_q[2*W-1:W];

    // write decode
    wire do_write = aw_have_q & w_have_q & ~bvalid_q;
    wire [timer_io_pkg::ADDR_W-1:0] aw_word =
        {aw_addr_q[timer_io_pkg::ADDR_W-1:WORD_LSB_P], 2'h0};
    wire wr_ch1 = do_write & w_strb_q &
                  (aw_word == timer_io_pkg::OFF_CH1_CTRL);
    wire wr_ch2 = do_write & w_strb_q &
                  (aw_word == timer_io_pkg::OFF_CH2_CTRL);
    wire aw_mapped = (aw_word <= timer_io_pkg::OFF_CAP_LAST);

    assign fld_wr = {wr_ch2, wr_ch2, wr_ch1, wr_ch1};

    // read decode
    wire [timer_io_pkg::ADDR_W-1:0] ar_word =
        {araddr[timer_io_pkg::ADDR_W-1:WORD_LSB_P], 2'h0};
    wire [timer_io_pkg::ADDR_W-1:0] ar_cap_off =
        ar_word - timer_io_pkg::OFF_CAP_BASE;
    wire [1:0] ar_cap_idx = ar_cap_off[WORD_LSB_P+1:WORD_LSB_P];
    wire ar_is_cap = (ar_word >= timer_io_pkg::OFF_CAP_BASE) &
                     (ar_word <= timer_io_pkg::OFF_CAP_LAST);
    wire ar_mapped = (ar_word <= timer_io_pkg::OFF_CAP_LAST);
    wire [timer_io_pkg::DATA_W-1:0] rd_mux =
        (ar_word == timer_io_pkg::OFF_CH1_CTRL) ?
            {24'h000000, ch1_ctrl_q} :
        (ar_word == timer_io_pkg::OFF_CH2_CTRL) ?
            {24'h000000, ch2_ctrl_q} :
        (ar_word == timer_io_pkg::OFF_PIN_STAT) ?
            {16'h0000, ~oe_n_q, level_q, 4'h0, pin_s2_q} :
        ar_is_cap ? {16'h0000, cap_q[ar_cap_idx]} :
            32'h00000000;

    // per register function logic
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_reg
            wire [1:0] act = fld[i][timer_io_pkg::FLD_ACT_LSB +:
                                    timer_io_pkg::FLD_ACT_W];
            wire is_cap = fld[i][timer_io_pkg::FLD_CAPTURE_BIT];
            wire alt    = fld[i][timer_io_pkg::FLD_ALT_BIT];
            wire rise   = pin_s2_q[i] & ~pin_s3_q[i];
            wire fall   = ~pin_s2_q[i] & pin_s3_q[i];
            wire ch0_ev = (i == 0) ? events.ch0_a_event
                                   : events.ch0_c_event;
            wire pin_trig =
                (act == timer_io_pkg::EDGE_RISE) ? rise :
                (act == timer_io_pkg::EDGE_FALL) ? fall :
                (act == timer_io_pkg::EDGE_BOTH) ? rise | fall
                : (~alt & (rise | fall));
            wire trig_ch1 = alt ? ch0_ev : pin_trig;
            assign cap_trig[i] = is_cap &
                ((i < 2) ? trig_ch1 : pin_trig);
            assign cap_d[i] = cap_trig[i] ? count_value : cap_q[i];
            // compare output: disabled codes and capture leave pin free
            wire drive = ~is_cap & (act != timer_io_pkg::ACT_NONE);
            wire hit = drive & events.match[i];
            assign oe_n_d[i] = ~drive;
            assign level_d[i] =
                fld_wr[i] ? w_data_q[i%2*W + timer_io_pkg::FLD_ALT_BIT] :
                ~hit ? level_q[i] :
                (act == timer_io_pkg::ACT_LOW)  ? 1'b0 :
                (act == timer_io_pkg::ACT_HIGH) ? 1'b1 :
                ~level_q[i];
        end
    endgenerate

    // lowest index wins when captures collide on the shared value port
    always_comb begin
        cap_val_d = cap_val_q;
        for (int k = N - 1; k >= 0; k--) begin
            if (cap_trig[k]) begin
                cap_val_d = count_value;
            end
        end
    end

    // control registers, reset to output disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch1_ctrl_q <= timer_io_pkg::CTRL_RESET;
            ch2_ctrl_q <= timer_io_pkg::CTRL_RESET;
        end else begin
            if (wr_ch1) begin
                ch1_ctrl_q <= w_data_q;
            end
            if (wr_ch2) begin
                ch2_ctrl_q <= w_data_q;
            end
        end
    end

    // pin synchroniser, drive and capture registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q  <= LEVEL_RESET_P;
            pin_s2_q  <= LEVEL_RESET_P;
            pin_s3_q  <= LEVEL_RESET_P;
            level_q   <= LEVEL_RESET_P;
            oe_n_q    <= timer_io_pkg::OE_N_RESET;
            cap_stb_q <= LEVEL_RESET_P;
            cap_val_q <= timer_io_pkg::CAP_RESET;
            for (int k = 0; k < N; k++) begin
                cap_q[k] <= timer_io_pkg::CAP_RESET;
            end
        end else begin
            pin_s1_q  <= pin_in;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            level_q   <= level_d;
            oe_n_q    <= oe_n_d;
            cap_stb_q <= cap_trig;
            cap_val_q <= cap_val_d;
            cap_q     <= cap_d;
        end
    end

    // axi write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= timer_io_pkg::OFF_CH1_CTRL;
            w_data_q  <= timer_io_pkg::CTRL_RESET;
            w_strb_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= timer_io_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_have_q <= 1'b1;
                w_data_q <= wdata[timer_io_pkg::CTRL_W-1:0];
                w_strb_q <= wstrb[0];
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= aw_mapped ? timer_io_pkg::RESP_OKAY
                                      : timer_io_pkg::RESP_SLVERR;
            end
            if (bvalid_q && bready) begin
                bvalid_q  <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= timer_io_pkg::RESP_OKAY;
            rdata_q   <= 32'h00000000;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= ar_mapped ? timer_io_pkg::RESP_OKAY
                                   : timer_io_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // outputs, all straight from flip-flops
    assign awready   = awready_q;
    assign wready    = wready_q;
    assign bvalid    = bvalid_q;
    assign bresp     = bresp_q;
    assign arready   = arready_q;
    assign rvalid    = rvalid_q;
    assign rresp     = rresp_q;
    assign rdata     = rdata_q;
    assign pin_drive = '{level: level_q, oe_n: oe_n_q};
    assign capture   = '{strobe: cap_stb_q, value: cap_val_q};

endmodule

// file: verilog/timer_io_pkg.sv
// constants and carrier types of the timer channel 1/2 pin control block
// assumes a 40 MHz peripheral clock and an AXI4-Lite master in front
package timer_io_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int CTRL_W = 8;
    localparam int FLD_W  = 4;
    localparam int N_REG  = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CH1_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CH2_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PIN_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CAP_BASE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_CAP_LAST = 8'h18;
    localparam int                WORD_LSB     = 2;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET  = 8'h00;
    localparam logic [CNT_W-1:0]  CAP_RESET   = 16'h0000;
    localparam logic [N_REG-1:0]  LEVEL_RESET = 4'h0;
    localparam logic [N_REG-1:0]  OE_N_RESET  = 4'hf;

    // function field layout
    localparam int FLD_CAPTURE_BIT = 3;
    localparam int FLD_ALT_BIT     = 2;
    localparam int FLD_ACT_LSB     = 0;
    localparam int FLD_ACT_W       = 2;

    // action codes in the low two field bits
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] EDGE_RISE  = 2'h0;
    localparam logic [1:0] EDGE_FALL  = 2'h1;
    localparam logic [1:0] EDGE_BOTH  = 2'h2;
    localparam logic [1:0] EDGE_BOTH2 = 2'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // index 0 ch1 reg a, 1 ch1 reg b, 2 ch2 reg a, 3 ch2 reg b
    typedef struct packed {
        logic [N_REG-1:0] match;
        logic             ch0_a_event;
        logic             ch0_c_event;
    } timer_events_t;

    typedef struct packed {
        logic [N_REG-1:0] level;
        logic [N_REG-1:0] oe_n;
    } pin_drive_t;

    typedef struct packed {
        logic [N_REG-1:0] strobe;
        logic [CNT_W-1:0] value;
    } capture_t;

endpackage

// file: bench/timer_io_properties.sv
// port checker for the timer channel 1/2 pin control block
// assumes one clock and the block's synchronous active-low reset
`timescale 1ns/10ps
module timer_io_properties (
    // clock and reset
    input wire logic                        aclk, aresetn,
    // bus
    input wire logic                        awvalid, awready, wvalid, wready,
    input wire logic                        bvalid, bready, arvalid, arready,
    input wire logic                        rvalid, rready,
    // timer side
    input wire logic [15:0]                 count_value,
    input wire timer_io_pkg::timer_events_t events,
    input wire timer_io_pkg::capture_t      capture,
    input wire timer_io_pkg::pin_drive_t    pin_drive
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wr_go = awvalid && awready && wvalid && wready;
    a_reset_idle: assert property ($rose(aresetn) |->
        pin_drive.oe_n == 4'hf && !bvalid && !rvalid)
        else $error("block not idle after reset");
    a_write_resp: assert property (wr_go |-> ##2 bvalid)
        else $error("write response late");
    a_write_busy: assert property (wr_go |=> !awready && !wready)
        else $error("write channels ready while busy");
    a_resp_done: assert property (bvalid && bready |=>
        !bvalid && awready && wready)
        else $error("write response not retired");
    a_read_resp: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_read_done: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read data not retired");
    a_cap_value: assert property (|capture.strobe |->
        capture.value == $past(count_value))
        else $error("captured value is not the counter");
    a_level_cause: assert property ($changed(pin_drive.level) |->
        $past(|events.match) || $past(wr_go) || $past(!awready))
        else $error("pin level moved without match or write");
    a_oe_cause: assert property ($changed(pin_drive.oe_n) |->
        $past(wr_go) || $past(!awready))
        else $error("pin enable moved without write");
    c_capture: cover property (|capture.strobe);
    c_write: cover property (bvalid && bready);
    c_match: cover property (|events.match);
endmodule

bind timer_channel_io_control timer_io_properties timer_io_properties_i (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .arvalid, .arready, .rvalid, .rready, .count_value, .events,
    .capture, .pin_drive);

// file: bench/pin_model.sv
// board side of the four timer pins
// assumes the block drives a pin only while its oe_n bit is low
`timescale 1ns/10ps
module pin_model (
    // block drive and board level
    input wire timer_io_pkg::pin_drive_t pin_drive,
    input wire logic [3:0]               ext_level,
    // resolved pins
    output logic [3:0]                   pin_in
);
    // pins settle off the clock edge, unrelated to it
    assign #7 pin_in = (pin_drive.level & ~pin_drive.oe_n)
                     | (ext_level & pin_drive.oe_n);
endmodule

// file: bench/tb_top.sv
// self-checking bench of the timer channel 1/2 pin control block
// assumes the pin model on the pins and the checker bound inside
`timescale 1ns/10ps
module tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0, v;
    logic [31:0] wdata = 0, rdata, d, ns = 0, s = 32'd85220;
    logic [3:0] wstrb = 4'hf, pin_in, ext = 0, c;
    logic [1:0] bresp, rresp, r;
    logic [15:0] cnt = 0;
    logic lv;
    timer_io_pkg::timer_events_t ev = '0;
    timer_io_pkg::capture_t cap;
    timer_io_pkg::pin_drive_t pd;
    int miscompares = 0, n_checks = 0, cyc = 0, sel = 0;
    always #12.5 aclk = ~aclk;
    timer_channel_io_control timer_channel_io_control_i (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .count_value(cnt), .events(ev), .capture(cap), .pin_in,
        .pin_drive(pd));
    pin_model pin_model_i (.pin_drive(pd), .ext_level(ext), .pin_in);
    // strobe counter of the selected index and run limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cap.strobe[sel] === 1'b1) ns <= ns + 1;
        if (cyc > 10000) begin
            miscompares++;
            results();
        end
    end
    function logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function logic oc_level(logic [3:0] f, logic prev);
        return f[1:0] == 2'h1 ? 1'b0 : f[1:0] == 2'h2 ? 1'b1 : ~prev;
    endfunction
    // pin edge kinds a capture field answers
    function logic cap_on(int i, logic [3:0] f, logic rise);
        if (f[2] && (i < 2 || f[1:0] == 2'h3)) return 1'b0;
        return rise ? f[1:0] != 2'h1 : f[1:0] != 2'h0;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] x, input logic [3:0] st);
        logic pa, pb;
        pa = 1;
        pb = 1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= x;
        wstrb <= st;
        {awvalid, wvalid, bready} <= 3'h7;
        while (pb) begin
            @(posedge aclk);
            if (!pa && bvalid === 1'b1) begin
                pb = 0;
                bready <= 1'b0;
                r = bresp;
            end
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (awready === 1'b1 && wready === 1'b1) pa = 0;
        end
    endtask
    task rd(input logic [7:0] a);
        logic pa, pr;
        pa = 1;
        pr = 1;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (pr) begin
            @(posedge aclk);
            if (!pa && rvalid === 1'b1) begin
                pr = 0;
                rready <= 1'b0;
                d = rdata;
                r = rresp;
            end
            if (arready === 1'b1) begin
                pa = 0;
                arvalid <= 1'b0;
            end
        end
    endtask
    task pulse(input logic [5:0] e);
        @(posedge aclk);
        ev <= e;
        @(posedge aclk);
        ev <= '0;
        tick(2);
    endtask
    task results();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task setf(input int i, input logic [3:0] f);
        c = f;
        sel = i;
        wr(8'(i / 2 * 4), 32'(f) << (i % 2 * 4), 4'hf);
        tick(6);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(8'h00);
        chk(d, 0);
        rd(8'h08);
        chk(d, 0);
        rd(8'h1c);
        chk({d[29:0], r}, 32'h2);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            v = 8'(rnd());
            wr(k[0] ? 8'h04 : 8'h00, rnd() & 32'hffffff00 | v, 4'hf);
            chk(32'(r), 32'h0);
            wr(k[0] ? 8'h04 : 8'h00, {24'h0, ~v}, 4'h0);
            rd(k[0] ? 8'h04 : 8'h00);
            chk(d & 32'hff, {24'h0, v});
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) for (int k = 0; k < 8; k++) begin
            setf(i, 4'(k));
            lv = c[2];
            chk(32'(pd.oe_n[i]), 32'(c[1:0] == 2'h0));
            if (c[1:0] != 2'h0) begin
                chk(32'(pd.level[i]), 32'(lv));
                for (int p = 0; p < 2; p++) begin
                    pulse(6'h4 << i);
                    lv = oc_level(c, lv);
                    chk(32'(pd.level[i]), 32'(lv));
                end
            end
        end
        $display("test compare done");
        for (int i = 0; i < 4; i++) for (int k = 8; k < 16; k++) begin
            cnt <= 16'(rnd());
            setf(i, 4'(k));
            chk(32'(pd.oe_n[i]), 1);
            for (int e = 0; e < 2; e++) begin
                ns <= 0;
                ext[i] <= e == 0;
                tick(6);
                chk(ns, 32'(cap_on(i, c, e == 0)));
            end
            ns <= 0;
            pulse(6'h2);
            chk(ns, 32'(i == 0 && c[2]));
            ns <= 0;
            pulse(6'h1);
            chk(ns, 32'(i == 1 && c[2]));
            rd(8'h0c + 8'(i * 4));
            if (c != 4'hf || i < 2) chk(d, {16'h0, cnt});
            if (c != 4'hf || i < 2) chk(32'(cap.value), {16'h0, cnt});
        end
        $display("test capture done");
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(8'h04);
        chk(d, 0);
        chk(32'(pd.oe_n), 32'hf);
        $display("test second reset done");
        results();
    end
endmodule
